// *** core/sfa_arbiter.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Requests of the three features that share the sense pin are resolved by a fixed order-dependent precedence.
// - With auto-restart already active, a later blanking request is ignored and auto-restart stays.
// - With blanking running, a later auto-restart request wins and the blanking period is abandoned.
// - With blanking running, a later brownout waits until blanking ends and the overload fault is gone.
// - With brownout active, a later auto-restart request is ignored and brownout stays.
// - If the overload clears before blanking ends while brownout is pending, brownout waits a 20 ms buffer.
// - During brownout all switching is suppressed and the input voltage sense stays monitored.
// - Brownout is left when the sensed voltage reaches its reference and re-entered when it falls below.
module sfa_arbiter #(
  parameter int unsigned BUFFER_CYCLES = sfa_pkg::SFA_BUFFER_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire sfa_pkg::sfa_feature_type request,
  input  wire logic                     overload_fault,
  input  wire logic                     blanking_done,
  output var  sfa_pkg::sfa_feature_type select,
  output var  logic                     switching_inhibit,
  output var  logic                     voltage_monitor,
  output var  logic                     blanking_abort
);
  import sfa_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // The requests come from analog comparators on the sense pin, so they
  // cross into this clock through two flip-flops before any decision.
  sfa_feature_type sync_meta;
  sfa_feature_type req;
  logic            overload_meta;
  logic            overload;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      // Brownout is on at start-up, so the synchronisers come out of reset
      // asking for it; otherwise switching could slip through for two cycles.
      sync_meta     <= SFA_RESET_SELECT;
      req           <= SFA_RESET_SELECT;
      overload_meta <= 1'b0;
      overload      <= 1'b0;
    end else begin
      sync_meta     <= request;
      req           <= sync_meta;
      overload_meta <= overload_fault;
      overload      <= overload_meta;
    end
  end

  // ****************************************************************
  // Buffer timer
  // ****************************************************************
  logic timer_start;
  logic timer_abort;
  logic timer_running;
  logic timer_done;

  sfa_buffer_timer #(
    .CYCLES (BUFFER_CYCLES)
  ) sfa_buffer_timer_i (
    .clock   (clock),
    .resetn  (resetn),
    .start   (timer_start),
    .abort   (timer_abort),
    .running (timer_running),
    .done    (timer_done)
  );

  // ****************************************************************
  // Feature arbitration
  // ****************************************************************
  sfa_state_type   state;
  sfa_state_type   next_state;
  logic            pending;
  logic            next_pending;
  sfa_feature_type next_select;
  logic            next_abort;

  function automatic sfa_feature_type decode_select(input sfa_state_type s);
    sfa_feature_type f;
    f             = '0;
    f.autorestart = (s == SFA_AUTORESTART);
    f.blanking    = (s == SFA_BLANKING) || (s == SFA_BLANK_WAIT);
    f.brownout    = (s == SFA_BROWNOUT);
    return f;
  endfunction : decode_select

  always_comb begin
    next_state   = state;
    next_pending = pending;
    next_abort   = 1'b0;
    timer_start  = 1'b0;
    timer_abort  = 1'b0;
    unique case (state)
      SFA_IDLE: begin
        // Requests that appear together: brownout, then auto-restart, then blanking.
        if (req.brownout) begin
          next_state = SFA_BROWNOUT;
        end else if (req.autorestart) begin
          next_state = SFA_AUTORESTART;
        end else if (req.blanking) begin
          next_state   = SFA_BLANKING;
          next_pending = 1'b0;
        end
      end
      SFA_AUTORESTART: begin
        // Blanking and brownout arriving later are both held off here.
        if (!req.autorestart) begin
          next_state = SFA_IDLE;
        end
      end
      SFA_BLANKING: begin
        if (req.autorestart) begin
          next_state   = SFA_AUTORESTART;
          next_abort   = 1'b1;
          next_pending = 1'b0;
        end else begin
          if (req.brownout) begin
            next_pending = 1'b1;
          end
          if (blanking_done) begin
            next_state = (pending || req.brownout) ? SFA_BLANK_WAIT : SFA_IDLE;
          end else if (!overload) begin
            if (pending || req.brownout) begin
              // Overload gone early: brownout must still wait out the buffer.
              next_state  = SFA_BUFFER;
              timer_start = 1'b1;
              next_abort  = 1'b1;
            end else begin
              next_state = SFA_IDLE;
              next_abort = 1'b1;
            end
          end
        end
      end
      SFA_BLANK_WAIT: begin
        // Blanking has finished; brownout acts only once the fault is gone.
        if (req.autorestart) begin
          next_state   = SFA_AUTORESTART;
          next_pending = 1'b0;
        end else if (!overload) begin
          next_state   = req.brownout ? SFA_BROWNOUT : SFA_IDLE;
          next_pending = 1'b0;
        end
      end
      SFA_BUFFER: begin
        if (req.autorestart) begin
          next_state   = SFA_AUTORESTART;
          next_pending = 1'b0;
          timer_abort  = 1'b1;
        end else if (timer_done) begin
          next_state   = req.brownout ? SFA_BROWNOUT : SFA_IDLE;
          next_pending = 1'b0;
        end
      end
      SFA_BROWNOUT: begin
        // Auto-restart and blanking requests are disregarded until the voltage recovers.
        if (!req.brownout) begin
          next_state = SFA_IDLE;
        end
      end
    endcase
    next_select = decode_select(next_state);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state             <= SFA_RESET_STATE;
      pending           <= 1'b0;
      select            <= SFA_RESET_SELECT;
      switching_inhibit <= 1'b1;
      voltage_monitor   <= 1'b1;
      blanking_abort    <= 1'b0;
    end else begin
      state             <= next_state;
      pending           <= next_pending;
      select            <= next_select;
      switching_inhibit <= next_select.brownout;
      voltage_monitor   <= next_select.brownout;
      blanking_abort    <= next_abort;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Cycles spent in the buffer state, counted apart from the timer so that
  // the interval check does not merely repeat the timer's own decision.
  logic [31:0] buffer_age;
  logic [31:0] next_buffer_age;

  always_comb begin
    next_buffer_age = 32'h0;
    if (state == SFA_BUFFER) begin
      next_buffer_age = buffer_age + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      buffer_age <= 32'h0;
    end else begin
      buffer_age <= next_buffer_age;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence blank_early_clear_s;
    (state == SFA_BLANKING) && !req.autorestart && !blanking_done && !overload
      && (pending || req.brownout);
  endsequence

  sequence buffer_exit_s;
    $rose(select.brownout) && ($past(state) == SFA_BUFFER);
  endsequence

  one_feature_a: assert property ($onehot0(select))
    else $error("More than one feature selected.");

  ar_keeps_a: assert property ((state == SFA_AUTORESTART) && req.autorestart && req.blanking
                               |=> select.autorestart && !select.blanking)
    else $error("Blanking displaced an active auto-restart.");

  ar_overrides_a: assert property ((state == SFA_BLANKING) && req.autorestart
                                   |=> select.autorestart && blanking_abort)
    else $error("Auto-restart did not override running blanking.");

  blank_runs_a: assert property ((state == SFA_BLANKING) && req.brownout && overload
                                 && !blanking_done && !req.autorestart
                                 |=> select.blanking && !select.brownout)
    else $error("Brownout cut a running blanking period short.");

  bo_keeps_a: assert property ((state == SFA_BROWNOUT) && req.brownout && req.autorestart
                               |=> select.brownout && !select.autorestart)
    else $error("Auto-restart displaced an active brownout.");

  buffer_wait_a: assert property (buffer_exit_s |-> buffer_age >= BUFFER_CYCLES)
    else $error("Brownout acted inside the buffer interval.");

  buffer_entry_a: assert property (blank_early_clear_s
                                   |=> (state == SFA_BUFFER) && blanking_abort
                                   && (select == '0))
    else $error("Early overload clear did not start the buffer interval.");

  inhibit_a: assert property (select.brownout |-> switching_inhibit && voltage_monitor
                              ##1 (select.brownout == switching_inhibit))
    else $error("Switching not suppressed during brownout.");

  bo_exit_a: assert property ((state == SFA_BROWNOUT) && !req.brownout
                              |=> !select.brownout ##1 !switching_inhibit || select.brownout)
    else $error("Brownout not left after voltage recovered.");

  bo_enter_a: assert property ((state == SFA_IDLE) && req.brownout |=> select.brownout)
    else $error("Brownout not re-entered after voltage fell.");

  bo_retain_a: assert property ((state == SFA_BROWNOUT) && req.brownout && req.blanking
                                |=> select.brownout)
    else $error("Blanking displaced an active brownout.");

  ar_retain_a: assert property ((state == SFA_AUTORESTART) && req.autorestart && req.brownout
                                |=> select.autorestart)
    else $error("Brownout displaced an active auto-restart.");

endmodule : sfa_arbiter
`default_nettype wire

// *** core/sfa_pkg.sv ***
// ****************************************************************
// Shared sense pin feature arbiter constants and types
// ****************************************************************
package sfa_pkg;

  // Each feature as seen on the shared sense pin, and the selection.
  typedef struct packed {
    logic autorestart;
    logic blanking;
    logic brownout;
  } sfa_feature_type;

  typedef enum logic [2:0] {
    SFA_IDLE,
    SFA_AUTORESTART,
    SFA_BLANKING,
    SFA_BLANK_WAIT,
    SFA_BUFFER,
    SFA_BROWNOUT
  } sfa_state_type;

  localparam int unsigned    SFA_SYNC_STAGES   = 2;
  localparam int unsigned    SFA_CLOCK_KHZ     = 100_000;
  localparam int unsigned    SFA_BUFFER_MS     = 20;
  localparam int unsigned    SFA_BUFFER_CYCLES = SFA_BUFFER_MS * SFA_CLOCK_KHZ;
  localparam sfa_state_type  SFA_RESET_STATE   = SFA_BROWNOUT;
  localparam sfa_feature_type SFA_RESET_SELECT = '{autorestart: 1'b0,
                                                   blanking:    1'b0,
                                                   brownout:    1'b1};

endpackage : sfa_pkg

// *** core/sfa_buffer_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Buffer interval timer
// ****************************************************************
module sfa_buffer_timer #(
  parameter int unsigned CYCLES = sfa_pkg::SFA_BUFFER_CYCLES
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic start,
  input  wire logic abort,
  output var  logic running,
  output var  logic done
);
  import sfa_pkg::*;

  localparam int unsigned WIDTH = $clog2(CYCLES + 1);
  localparam logic [WIDTH-1:0] LOAD = WIDTH'(CYCLES - 1);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_running;
  logic             next_done;

  // The done pulse is registered in the cycle after the count reaches zero, so start to done spans CYCLES + 1 edges.
  always_comb begin
    next_count   = count;
    next_running = running;
    next_done    = 1'b0;
    if (abort) begin
      next_running = 1'b0;
      next_count   = '0;
    end else if (start) begin
      next_running = 1'b1;
      next_count   = LOAD;
    end else if (running) begin
      if (count == '0) begin
        next_running = 1'b0;
        next_done    = 1'b1;
      end else begin
        next_count = count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
      done    <= next_done;
    end
  end

endmodule : sfa_buffer_timer
`default_nettype wire

// *** verif/sfa_arbiter_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Self-checking bench for the shared sense pin feature arbiter
// ****************************************************************
module sfa_arbiter_tb;
  import sfa_pkg::*;

  localparam int unsigned BUF = 20;
  localparam int unsigned CEILING = 4000;

  logic            clock = 1'b0;
  logic            resetn = 1'b0;
  sfa_feature_type request = '0;
  logic            overload_fault = 1'b0;
  logic            blanking_done = 1'b0;
  sfa_feature_type select;
  logic            switching_inhibit;
  logic            voltage_monitor;
  logic            blanking_abort;
  int              err_count = 0;
  int              comparisons = 0;
  int              cycles = 0;
  int              waited;
  logic            abort_seen;

  sfa_arbiter #(.BUFFER_CYCLES(BUF)) sfa_arbiter_i (
    .clock             (clock),
    .resetn            (resetn),
    .request           (request),
    .overload_fault    (overload_fault),
    .blanking_done     (blanking_done),
    .select            (select),
    .switching_inhibit (switching_inhibit),
    .voltage_monitor   (voltage_monitor),
    .blanking_abort    (blanking_abort)
  );

  always #5 clock = ~clock;

  // A hung handshake must still reach the closing report.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  // ****************************************************************
  // Compare and drive helpers
  // ****************************************************************
  task automatic check_sel(input sfa_feature_type got, input sfa_feature_type exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_sel

  task automatic check_bit(input logic got, input logic exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // Polls until select matches, noting any abort pulse seen on the way.
  task automatic wait_sel(input sfa_feature_type exp, input int max, output int n);
    #1;
    n = 0;
    abort_seen = 1'b0;
    while (select !== exp && n < max) begin
      step(1);
      n = n + 1;
      if (blanking_abort === 1'b1) abort_seen = 1'b1;
    end
    check_sel(select, exp);
  endtask : wait_sel

  task automatic drive(input logic [2:0] req, input logic ovl);
    @(posedge clock);
    request        <= sfa_feature_type'(req);
    overload_fault <= ovl;
  endtask : drive

  task automatic go_idle();
    @(posedge clock);
    resetn         <= 1'b0;
    request        <= '0;
    overload_fault <= 1'b0;
    step(20);
    @(posedge clock);
    resetn <= 1'b1;
    step(1);
    check_sel(select, sfa_feature_type'(3'b001));
    check_bit(switching_inhibit, 1'b1);
    check_bit(voltage_monitor, 1'b1);
    step(4);
    check_sel(select, '0);
    check_bit(switching_inhibit, 1'b0);
    check_bit(voltage_monitor, 1'b0);
  endtask : go_idle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic brownout_cycle();
    go_idle();
    drive(3'b001, 1'b0);
    step(3);
    check_sel(select, sfa_feature_type'(3'b001));
    check_bit(voltage_monitor, 1'b1);
    drive(3'b101, 1'b0);
    step(6);
    check_sel(select, sfa_feature_type'(3'b001));
    drive(3'b111, 1'b1);
    step(6);
    check_sel(select, sfa_feature_type'(3'b001));
    check_bit(switching_inhibit, 1'b1);
    drive(3'b000, 1'b0);
    step(3);
    check_sel(select, '0);
    check_bit(voltage_monitor, 1'b0);
    drive(3'b001, 1'b0);
    step(3);
    check_sel(select, sfa_feature_type'(3'b001));
  endtask : brownout_cycle

  task automatic blank_then_restart();
    go_idle();
    drive(3'b010, 1'b1);
    step(3);
    check_sel(select, sfa_feature_type'(3'b010));
    check_bit(switching_inhibit, 1'b0);
    drive(3'b110, 1'b1);
    step(3);
    check_sel(select, sfa_feature_type'(3'b100));
    check_bit(blanking_abort, 1'b1);
    step(1);
    check_bit(blanking_abort, 1'b0);
  endtask : blank_then_restart

  task automatic restart_holds();
    go_idle();
    drive(3'b100, 1'b1);
    step(3);
    check_sel(select, sfa_feature_type'(3'b100));
    drive(3'b110, 1'b1);
    step(6);
    check_sel(select, sfa_feature_type'(3'b100));
    drive(3'b111, 1'b1);
    step(6);
    check_sel(select, sfa_feature_type'(3'b100));
  endtask : restart_holds

  task automatic blank_then_brownout();
    go_idle();
    drive(3'b010, 1'b1);
    step(3);
    drive(3'b011, 1'b1);
    step(8);
    check_sel(select, sfa_feature_type'(3'b010));
    @(posedge clock);
    blanking_done <= 1'b1;
    request       <= sfa_feature_type'(3'b001);
    @(posedge clock);
    blanking_done <= 1'b0;
    step(6);
    check_sel(select, sfa_feature_type'(3'b010));
    drive(3'b001, 1'b0);
    wait_sel(sfa_feature_type'(3'b001), 8, waited);
    check_bit(waited <= 4, 1'b1);
  endtask : blank_then_brownout

  task automatic early_clear_buffer();
    go_idle();
    drive(3'b010, 1'b1);
    step(3);
    drive(3'b011, 1'b1);
    step(4);
    drive(3'b011, 1'b0);
    wait_sel('0, 8, waited);
    check_bit(abort_seen | blanking_abort, 1'b1);
    wait_sel(sfa_feature_type'(3'b001), BUF + 10, waited);
    check_bit(waited >= BUF && waited <= BUF + 3, 1'b1);
  endtask : early_clear_buffer

  // Auto-restart inside the buffer wins; a plain blanking whose fault clears is dropped.
  task automatic buffer_restart();
    go_idle();
    drive(3'b010, 1'b1);
    step(3);
    drive(3'b011, 1'b1);
    step(4);
    drive(3'b011, 1'b0);
    wait_sel('0, 8, waited);
    drive(3'b111, 1'b0);
    step(3);
    check_sel(select, sfa_feature_type'(3'b100));
    drive(3'b000, 1'b0);
    step(3);
    drive(3'b010, 1'b1);
    step(3);
    check_sel(select, sfa_feature_type'(3'b010));
    drive(3'b010, 1'b0);
    wait_sel('0, 8, waited);
    check_bit(abort_seen, 1'b1);
  endtask : buffer_restart

  task automatic simultaneous();
    go_idle();
    drive(3'b111, 1'b1);
    step(3);
    check_sel(select, sfa_feature_type'(3'b001));
    go_idle();
    drive(3'b110, 1'b1);
    step(3);
    check_sel(select, sfa_feature_type'(3'b100));
  endtask : simultaneous

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    brownout_cycle();
    blank_then_restart();
    restart_holds();
    blank_then_brownout();
    early_clear_buffer();
    buffer_restart();
    simultaneous();
    print_verdict();
  end

endmodule : sfa_arbiter_tb
`default_nettype wire
